// ### common/dmb_pkg.sv
// constants for the data-memory addressing front end
// assumes a single system clock and an AXI4-Lite register master
// Summary of operation
// - indirect port accesses never touch a register; they go via the paired pointer
// - paired pointer value is the effective address of an indirect access
// - pointer aimed at an indirect port: read gives 00H, write does nothing
// - first indirect port always reaches bank 0
// - second indirect port reaches the bank the selector names
// - direct accesses always reach bank 0; bank 1 only via second port
// - bank selector is bit 0 of its register, read/write
// - bank selector bits 7 to 1 read as zero
// - reset clears bank selector except timeout reset while idle or asleep
// - special-function locations other than 40H are the same in both banks
// - both pointers are real registers, incrementable like any other
// - writing pc low byte jumps within current page only
// - a pc low byte jump inserts one dummy cycle
// - table read places upper program word byte into table high latch
// - accumulator takes alu results; memory-to-memory moves go through it
// - table high latch is read-only, written only by table reads
// - location 40H holds eeprom control only in bank 1
// - each table read takes two instruction cycles
package dmb_pkg;
   localparam logic [7:0] DMB_A_IND_A = 8'h00;
   localparam logic [7:0] DMB_A_PTR_A = 8'h01;
   localparam logic [7:0] DMB_A_IND_B = 8'h02;
   localparam logic [7:0] DMB_A_PTR_B = 8'h03;
   localparam logic [7:0] DMB_A_BANK = 8'h04;
   localparam logic [7:0] DMB_A_ACC = 8'h05;
   localparam logic [7:0] DMB_A_PCL = 8'h06;
   localparam logic [7:0] DMB_A_TBLP = 8'h07;
   localparam logic [7:0] DMB_A_TABLE_HIGH_LATCH = 8'h08;
   localparam logic [7:0] DMB_A_EECTL = 8'h40;
   localparam logic [7:0] DMB_GP_BASE = 8'h41;
   // axi byte offsets of software registers
   localparam logic [7:0] DMB_AXI_IND_A = 8'h00;
   localparam logic [7:0] DMB_AXI_PTR_A = 8'h04;
   localparam logic [7:0] DMB_AXI_IND_B = 8'h08;
   localparam logic [7:0] DMB_AXI_PTR_B = 8'h0C;
   localparam logic [7:0] DMB_AXI_BANK = 8'h10;
   localparam logic [7:0] DMB_AXI_ACC = 8'h14;
   localparam logic [7:0] DMB_AXI_PCL = 8'h18;
   localparam logic [7:0] DMB_AXI_TBLP = 8'h1C;
   localparam logic [7:0] DMB_AXI_TABLE_HIGH_LATCH = 8'h20;
   localparam logic [7:0] DMB_AXI_PCHI = 8'h24;
   localparam logic [7:0] DMB_AXI_STAT = 8'h28;
   localparam logic [7:0] DMB_AXI_EECTL = 8'h2C;
   localparam logic [7:0] DMB_AXI_TBREAD = 8'h30;
   localparam logic [7:0] DMB_AXI_DIRECT = 8'h34;
   localparam logic [7:0] DMB_AXI_LAST = 8'h34;
   localparam int DMB_BANK_BIT = 0;
   localparam logic [7:0] DMB_BANK_RST = 8'h00;
   localparam int DMB_GP_WORDS = 64;
   localparam logic [2:0] DMB_PC_HI_RST = 3'h0;
   localparam logic [1:0] DMB_RESP_OK = 2'h0;
   localparam logic [1:0] DMB_RESP_ERR = 2'h2;
   typedef enum logic [1:0] {
      DMB_ST_RUN = 2'b00,
      DMB_ST_DUMMY = 2'b01,
      DMB_ST_TBL2 = 2'b10
   } dmb_state_t;
endpackage

// ### rtl/dmb_core.sv
// data-memory addressing front end with indirect ports and bank select
// assumes an AXI4-Lite master and a program-word source for table reads
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
module dmb_core
   import dmb_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic wdt_sleep_reset, // timeout reset while idle/sleep
   input wire logic [15:0] prog_word, // program word at table address
   input wire logic [7:0] alu_result, // alu output for accumulator
   input wire logic alu_load, // accumulator takes alu_result
   output logic [10:0] prog_addr, // table read address
   output logic [10:0] pc_out, // program counter
   output logic cpu_stall, // dummy or second table cycle
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read response valid
   input wire logic s_axi_rready // read response ready
);
   logic [7:0] ptr_a_q, ptr_b_q, acc_q, tblp_q, table_high_latch_q, eectl_q, dsel_q;
   logic bank_q, wdt_s1_q, wdt_s2_q;
   logic [2:0] pc_hi_q;
   logic [7:0] pc_lo_q;
   logic [7:0] gp0_q [DMB_GP_WORDS];
   logic [7:0] gp1_q [DMB_GP_WORDS];
   dmb_state_t st_q;
   logic aw_hold_q, w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_wr, do_rd, wr_en;
   logic [7:0] wr_byte;
   logic [7:0] rd_word;

   assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
   assign do_rd = s_axi_arvalid && s_axi_arready;
   assign wr_en = do_wr && wstrb_q[0];
   assign wr_byte = wdata_q[7:0];

   // resolved data-memory location: bank and address
   function automatic logic [8:0] resolve(input logic [7:0] port, input logic [7:0] pa,
                                         input logic [7:0] pb, input logic bk);
      logic [8:0] r;
      r = {1'b0, port};
      if (port == DMB_A_IND_A) begin
         r = {1'b0, pa};
      end else if (port == DMB_A_IND_B) begin
         r = {bk, pb};
      end
      return r;
   endfunction

   logic [8:0] eff_w, eff_r;
   logic ind_loop_w, ind_loop_r;
   assign eff_w = resolve(dsel_q, ptr_a_q, ptr_b_q, bank_q);
   assign eff_r = eff_w;
   assign ind_loop_w = (dsel_q == DMB_A_IND_A || dsel_q == DMB_A_IND_B)
                       && (eff_w[7:0] == DMB_A_IND_A || eff_w[7:0] == DMB_A_IND_B);
   assign ind_loop_r = ind_loop_w;

   // data port write targets
   logic dw_ptr_a, dw_ptr_b, dw_bank, dw_acc, dw_pcl, dw_tblp, dw_eec;
   logic dm_wr;
   assign dm_wr = wr_en && awaddr_q == DMB_AXI_DIRECT && !ind_loop_w;
   assign dw_ptr_a = (wr_en && awaddr_q == DMB_AXI_PTR_A) || (dm_wr && eff_w[7:0] == DMB_A_PTR_A);
   assign dw_ptr_b = (wr_en && awaddr_q == DMB_AXI_PTR_B) || (dm_wr && eff_w[7:0] == DMB_A_PTR_B);
   assign dw_bank = (wr_en && awaddr_q == DMB_AXI_BANK) || (dm_wr && eff_w[7:0] == DMB_A_BANK);
   assign dw_acc = (wr_en && awaddr_q == DMB_AXI_ACC) || (dm_wr && eff_w[7:0] == DMB_A_ACC);
   assign dw_pcl = ((wr_en && awaddr_q == DMB_AXI_PCL) || (dm_wr && eff_w[7:0] == DMB_A_PCL))
                   && st_q == DMB_ST_RUN;
   assign dw_tblp = (wr_en && awaddr_q == DMB_AXI_TBLP) || (dm_wr && eff_w[7:0] == DMB_A_TBLP);
   assign dw_eec = dm_wr && eff_w == {1'b1, DMB_A_EECTL};

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wdt_s1_q <= 1'b0;
         wdt_s2_q <= 1'b0;
      end else begin
         wdt_s1_q <= wdt_sleep_reset;
         wdt_s2_q <= wdt_s1_q;
      end
   end

   // bank kept by timeout-in-sleep reset; cleared by the async reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bank_q <= DMB_BANK_RST[DMB_BANK_BIT];
      end else if (dw_bank) begin
         bank_q <= wr_byte[DMB_BANK_BIT];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ptr_a_q <= 8'h00;
         ptr_b_q <= 8'h00;
      end else begin
         if (dw_ptr_a) ptr_a_q <= wr_byte;
         if (dw_ptr_b) ptr_b_q <= wr_byte;
      end
   end

   // table pointer; software loads it before a table read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tblp_q <= 8'h00;
      end else if (dw_tblp) begin
         tblp_q <= wr_byte;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 8'h00;
      end else if (alu_load) begin
         acc_q <= alu_result;
      end else if (dw_acc) begin
         acc_q <= wr_byte;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         eectl_q <= 8'h00;
      end else if (dw_eec) begin
         eectl_q <= wr_byte;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dsel_q <= 8'h00;
      end else if (wr_en && awaddr_q == DMB_AXI_STAT) begin
         dsel_q <= wr_byte;
      end
   end

   // general-purpose ram, one generate entry per word
   for (genvar i = 0; i < DMB_GP_WORDS; i++) begin : g_gp
      always_ff @(posedge clk_sys) begin
         if (dm_wr && eff_w[7:0] == DMB_GP_BASE + 8'(i)) begin
            if (eff_w[8]) gp1_q[i] <= wr_byte;
            else gp0_q[i] <= wr_byte;
         end
      end
   end

   // sequencer strobes; bus strobes only act while the core runs
   logic seq_run, tbl_go, pchi_wr;
   assign seq_run = st_q == DMB_ST_RUN;
   assign tbl_go = wr_en && awaddr_q == DMB_AXI_TBREAD && seq_run;
   assign pchi_wr = wr_en && awaddr_q == DMB_AXI_PCHI && seq_run;

   // sequencer state; a timeout reset in sleep drops any pending cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= DMB_ST_RUN;
      end else if (wdt_s2_q) begin
         st_q <= DMB_ST_RUN;
      end else begin
         unique case (st_q)
            DMB_ST_RUN: begin
               if (dw_pcl) begin
                  st_q <= DMB_ST_DUMMY;
               end else if (tbl_go) begin
                  st_q <= DMB_ST_TBL2;
               end
            end
            DMB_ST_DUMMY: begin
               st_q <= DMB_ST_RUN;
            end
            DMB_ST_TBL2: begin
               st_q <= DMB_ST_RUN;
            end
            default: begin
               st_q <= DMB_ST_RUN;
            end
         endcase
      end
   end

   // stall marks the dummy cycle and the second table cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cpu_stall <= 1'b0;
      end else if (wdt_s2_q) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= dw_pcl || tbl_go;
      end
   end

   // pc low byte: a write jumps inside the current page
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_lo_q <= 8'h00;
      end else if (wdt_s2_q) begin
         pc_lo_q <= 8'h00;
      end else if (dw_pcl) begin
         pc_lo_q <= wr_byte;
      end
   end

   // page bits are untouched by a pc low byte write
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pc_hi_q <= DMB_PC_HI_RST;
      end else if (wdt_s2_q) begin
         pc_hi_q <= DMB_PC_HI_RST;
      end else if (pchi_wr) begin
         pc_hi_q <= wr_byte[2:0];
      end
   end
   assign pc_out = {pc_hi_q, pc_lo_q};

   // table address: current page when bit 0 is set, else last page
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prog_addr <= 11'h000;
      end else if (tbl_go) begin
         prog_addr <= wr_byte[DMB_BANK_BIT] ? {pc_hi_q, tblp_q} : {3'h7, tblp_q};
      end
   end

   // high byte lands in the second table cycle, only from a table read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         table_high_latch_q <= 8'h00;
      end else if (st_q == DMB_ST_TBL2) begin
         table_high_latch_q <= prog_word[15:8];
      end
   end

   // read view of a data-memory location
   always_comb begin
      rd_word = 8'h00;
      if (ind_loop_r) begin
         rd_word = 8'h00;
      end else if (eff_r[7:0] >= DMB_GP_BASE && eff_r[7:0] < DMB_GP_BASE + 8'(DMB_GP_WORDS)) begin
         rd_word = eff_r[8] ? gp1_q[6'(eff_r[7:0] - DMB_GP_BASE)] : gp0_q[6'(eff_r[7:0] - DMB_GP_BASE)];
      end else begin
         unique case (eff_r[7:0])
            DMB_A_PTR_A: rd_word = ptr_a_q;
            DMB_A_PTR_B: rd_word = ptr_b_q;
            DMB_A_BANK: rd_word = {7'h00, bank_q};
            DMB_A_ACC: rd_word = acc_q;
            DMB_A_PCL: rd_word = pc_lo_q;
            DMB_A_TBLP: rd_word = tblp_q;
            DMB_A_TABLE_HIGH_LATCH: rd_word = table_high_latch_q;
            DMB_A_EECTL: rd_word = eff_r[8] ? eectl_q : 8'h00;
            default: rd_word = 8'h00;
         endcase
      end
   end

   // axi write channel; address and data may arrive in either order
   logic aw_take, w_take;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (aw_take) begin
         aw_hold_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         w_hold_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (w_take) begin
         w_hold_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end else if (do_wr) begin
         w_hold_q <= 1'b0;
      end
   end

   // response: error for a misaligned or unmapped word, write dropped
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= DMB_RESP_OK;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (awaddr_q[1:0] != 2'b00 || awaddr_q > DMB_AXI_LAST) ? DMB_RESP_ERR : DMB_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // registered readies: low from a take until the response is accepted
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !(aw_take || aw_hold_q || (s_axi_bvalid && !s_axi_bready));
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !(w_take || w_hold_q || (s_axi_bvalid && !s_axi_bready));
      end
   end

   // axi read channel; only the direct window resolves through rd_word, indirect ports read 00H
   logic [7:0] rd_sel;
   always_comb begin
      rd_sel = 8'h00;
      unique case (s_axi_araddr)
         DMB_AXI_IND_A: rd_sel = ptr_a_q == DMB_A_IND_A || ptr_a_q == DMB_A_IND_B ? 8'h00 : 8'h00;
         DMB_AXI_PTR_A: rd_sel = ptr_a_q;
         DMB_AXI_PTR_B: rd_sel = ptr_b_q;
         DMB_AXI_BANK: rd_sel = {7'h00, bank_q};
         DMB_AXI_ACC: rd_sel = acc_q;
         DMB_AXI_PCL: rd_sel = pc_lo_q;
         DMB_AXI_TBLP: rd_sel = tblp_q;
         DMB_AXI_TABLE_HIGH_LATCH: rd_sel = table_high_latch_q;
         DMB_AXI_PCHI: rd_sel = {5'h00, pc_hi_q};
         DMB_AXI_STAT: rd_sel = dsel_q;
         DMB_AXI_EECTL: rd_sel = eectl_q;
         DMB_AXI_DIRECT: rd_sel = rd_word;
         default: rd_sel = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= DMB_RESP_OK;
      end else if (do_rd) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_sel};
         s_axi_rresp <= (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > DMB_AXI_LAST) ? DMB_RESP_ERR : DMB_RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !(do_rd || (s_axi_rvalid && !s_axi_rready));
      end
   end
endmodule

// ### tb/dmb_prog_model.sv
// program memory as seen by table reads
// word pattern: upper byte = low address bits xor A5, lower = inverted
`timescale 1ns/1ns
module dmb_prog_model (
   input wire logic [10:0] prog_addr, // table read address
   output logic [15:0] prog_word // word at that address
);
   assign prog_word = {prog_addr[7:0] ^ 8'hA5, ~prog_addr[7:0]};
endmodule

// ### tb/dmb_core_monitor.sv
// assertions on the ports of the addressing front end
// assumes one clock domain and the AXI4-Lite contract of the core
`timescale 1ns/1ns
module dmb_core_monitor
   import dmb_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic rst_n, // reset
   input wire logic cpu_stall, // stall
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [7:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire ar_t = s_axi_arvalid && s_axi_arready;
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
   read_answer_a: assert property (ar_t |=> s_axi_rvalid) else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid) else $error("write answer late");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   bank_upper_a: assert property (ar_t && s_axi_araddr == DMB_AXI_BANK |=> s_axi_rdata[31:1] == 31'h0)
      else $error("bank register upper bits set");
   port_read_a: assert property (ar_t && (s_axi_araddr == DMB_AXI_IND_A || s_axi_araddr == DMB_AXI_IND_B)
      |=> s_axi_rdata == 32'h0) else $error("indirect port read as register");
   bad_addr_a: assert property (ar_t && s_axi_araddr > DMB_AXI_LAST
      |=> s_axi_rresp == DMB_RESP_ERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
   stall_once_a: assert property (cpu_stall |=> !cpu_stall) else $error("stall longer than one cycle");
   cover property (cpu_stall);
   cover property (s_axi_rvalid && s_axi_rresp == DMB_RESP_ERR);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind dmb_core dmb_core_monitor u_mon (.*);

// ### tb/data_memory_indirect_banking_bench.sv
// self-checking bench for the addressing front end
// drives AXI4-Lite, the alu inputs and the timeout marker
`timescale 1ns/1ns
module data_memory_indirect_banking_bench
   import dmb_pkg::*;
;
   typedef struct {logic [7:0] wa, wd, ra, ex;} dmb_row_t;
   logic clk_sys = 0, rst_n = 0, wdt = 0, alu_load = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, bvalid, arready, awready, wready, rvalid, cpu_stall;
   logic [7:0] alu_result = 0, awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, lrdata;
   logic [1:0] bresp, rresp, lresp, lrresp;
   logic [15:0] prog_word;
   logic [10:0] prog_addr, pc_out;
   int errors = 0, n_compared = 0, nstall = 0, s0;
   dmb_row_t rows [6] = '{'{DMB_AXI_BANK, 8'hFF, DMB_AXI_BANK, 8'h01}, '{DMB_AXI_PTR_A, 8'hC3, DMB_AXI_PTR_A, 8'hC3},
      '{DMB_AXI_PTR_B, 8'h3C, DMB_AXI_PTR_B, 8'h3C}, '{DMB_AXI_ACC, 8'h96, DMB_AXI_ACC, 8'h96},
      '{DMB_AXI_TBLP, 8'h5A, DMB_AXI_TBLP, 8'h5A}, '{DMB_AXI_TABLE_HIGH_LATCH, 8'hFF, DMB_AXI_TABLE_HIGH_LATCH, 8'h00}};
   dmb_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wdt_sleep_reset(wdt), .prog_word(prog_word),
      .alu_result(alu_result), .alu_load(alu_load), .prog_addr(prog_addr), .pc_out(pc_out),
      .cpu_stall(cpu_stall), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   dmb_prog_model u_prog (.prog_addr(prog_addr), .prog_word(prog_word));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (cpu_stall) nstall <= nstall + 1;
   end
   task automatic report_and_stop();
      if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      logic ta, tw, tb;
      n = 0;
      @(posedge clk_sys);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; lresp = bresp;
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) bready <= 1'b0;
         n++;
      end while (!tb && n < 50);
      if (!tb) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      logic ta, tr;
      n = 0;
      @(posedge clk_sys);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         ta = arvalid && arready; tr = rvalid; lrdata = rdata; lrresp = rresp;
         if (ta) arvalid <= 1'b0;
         if (tr) rready <= 1'b0;
         n++;
      end while (!tr && n < 50);
      if (!tr) begin
         errors++;
         report_and_stop();
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk("read", lrdata, {24'h0, e});
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         chk("bresp", {30'h0, lresp}, {30'h0, DMB_RESP_OK});
         rdc(rows[i].ra, rows[i].ex);
      end
      wr(8'h38, 8'h11);
      chk("bresp bad", {30'h0, lresp}, {30'h0, DMB_RESP_ERR});
      rd(8'h05);
      chk("rresp bad", {30'h0, lrresp}, {30'h0, DMB_RESP_ERR});
      wr(DMB_AXI_BANK, 8'h00); wr(DMB_AXI_PTR_A, 8'h41); wr(DMB_AXI_STAT, DMB_A_IND_A); wr(DMB_AXI_DIRECT, 8'h5A);
      wr(DMB_AXI_BANK, 8'h01); wr(DMB_AXI_PTR_B, 8'h41); wr(DMB_AXI_STAT, DMB_A_IND_B); wr(DMB_AXI_DIRECT, 8'h3C);
      rdc(DMB_AXI_DIRECT, 8'h3C);
      wr(DMB_AXI_STAT, DMB_A_IND_A);
      rdc(DMB_AXI_DIRECT, 8'h5A);
      wr(DMB_AXI_STAT, 8'h41);
      rdc(DMB_AXI_DIRECT, 8'h5A);
      wr(DMB_AXI_PTR_A, 8'h00); wr(DMB_AXI_STAT, DMB_A_IND_A); wr(DMB_AXI_DIRECT, 8'h99);
      rdc(DMB_AXI_DIRECT, 8'h00);
      wr(DMB_AXI_PTR_B, 8'h04); wr(DMB_AXI_STAT, DMB_A_IND_B);
      rdc(DMB_AXI_DIRECT, 8'h01);
      wr(DMB_AXI_PTR_B, 8'h40); wr(DMB_AXI_DIRECT, 8'h0A);
      rdc(DMB_AXI_EECTL, 8'h0A);
      @(posedge clk_sys);
      alu_result <= 8'h3E; alu_load <= 1'b1;
      @(posedge clk_sys);
      alu_load <= 1'b0;
      rdc(DMB_AXI_ACC, 8'h3E);
      wr(DMB_AXI_PCHI, 8'h03);
      rdc(DMB_AXI_PCHI, 8'h03);
      s0 = nstall;
      wr(DMB_AXI_PCL, 8'h77);
      rd(DMB_AXI_PCL);
      chk("pc", {21'h0, pc_out}, {21'h0, 3'h3, 8'h77});
      chk("stall", nstall - s0, 1);
      wr(DMB_AXI_TBLP, 8'h06);
      s0 = nstall;
      wr(DMB_AXI_TBREAD, 8'h00);
      rdc(DMB_AXI_TABLE_HIGH_LATCH, 8'hA3);
      chk("stall", nstall - s0, 1);
      chk("paddr", {21'h0, prog_addr}, {21'h0, 3'h7, 8'h06});
      wr(DMB_AXI_TBLP, 8'h07);
      wr(DMB_AXI_TBREAD, 8'h01);
      rdc(DMB_AXI_TABLE_HIGH_LATCH, 8'hA2);
      chk("paddr", {21'h0, prog_addr}, {21'h0, 3'h3, 8'h07});
      wr(DMB_AXI_BANK, 8'h01);
      wdt <= 1'b1;
      repeat (4) @(posedge clk_sys);
      wdt <= 1'b0;
      rdc(DMB_AXI_BANK, 8'h01);
      chk("pc wdt", {21'h0, pc_out}, {21'h0, DMB_PC_HI_RST, 8'h00});
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(DMB_AXI_BANK, 8'h00);
      report_and_stop();
   end
endmodule
